// >>> include/crc_mon_pkg.sv
// Constants shared by the link integrity monitor: map, fields, resets, timing.
package crc_mon_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int CHANNELS = 2;
  localparam int COUNT_WIDTH = 16;
  localparam int ADDR_WIDTH = 8;
  localparam int DATA_WIDTH = 32;

  // ****************************************************************
  // Register map, byte addresses
  // ****************************************************************
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] MASK_ADDR = 8'h08;
  // Channel c occupies 0x10*(c+1) .. 0x10*(c+1)+0x0C.
  localparam logic [1:0] FIELD_THRESHOLD = 2'h0;
  localparam logic [1:0] FIELD_WINDOW = 2'h1;
  localparam logic [1:0] FIELD_FAIL = 2'h2;
  localparam logic [1:0] FIELD_TOTAL = 2'h3;

  // Control bits.
  localparam int CTRL_RELAY_BIT = 0;
  localparam int CTRL_RATE_BIT = 1;

  // ****************************************************************
  // Reset values and CRC constants
  // ****************************************************************
  localparam logic [15:0] THRESHOLD_RST = 16'h000A;
  localparam logic [15:0] WINDOW_RST = 16'h0258;
  localparam logic [31:0] CRC_INIT = 32'hFFFFFFFF;
  localparam logic [31:0] CRC_POLY = 32'hEDB88320;
  localparam logic [31:0] CRC_RESIDUE = 32'hDEBB20E3;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLOCK_HZ = 40_000_000;
  localparam int INTEGRITY_MS_64K = 1000;
  localparam int INTEGRITY_MS_128K = 500;
  localparam int INTEGRITY_CYCLES_64K = CLOCK_HZ / 1000 * INTEGRITY_MS_64K;
  localparam int INTEGRITY_CYCLES_128K = CLOCK_HZ / 1000 * INTEGRITY_MS_128K;
  localparam int TIMER_WIDTH = 26;
  // Relay latency through the block in clock cycles.
  localparam int RELAY_LATENCY = 1;

endpackage

// >>> core/link_crc_error_rate_monitor.sv
// Per-channel message integrity monitor with relay and integrity beacon.
// How it works
// - Check each message with 32-bit CRC.
// - Count every received message per channel.
// - Separately count messages failing the check.
// - Raise alarm when failures reach threshold.
// - Window full clears both counters together.
// - Thresholds, windows and counters kept per channel; relay and rate shared.
// - Failure count readable as channel status.
// - Latency per hop fixed and small.
// - Middle device relays when configured.
// - Send both ways; surviving ring still delivers.
// - Periodic integrity message without output change.
module link_crc_error_rate_monitor #(
  parameter int CHANNEL_COUNT = crc_mon_pkg::CHANNELS,
  parameter int CW = crc_mon_pkg::COUNT_WIDTH,
  parameter int PERIOD_64K = crc_mon_pkg::INTEGRITY_CYCLES_64K,
  parameter int PERIOD_128K = crc_mon_pkg::INTEGRITY_CYCLES_128K
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic [crc_mon_pkg::ADDR_WIDTH-1:0] reg_addr_in,
  input wire logic [crc_mon_pkg::DATA_WIDTH-1:0] reg_wdata_in,
  input wire logic reg_write_in,
  input wire logic reg_read_in,
  output logic [crc_mon_pkg::DATA_WIDTH-1:0] reg_rdata_out,
  input wire logic [CHANNEL_COUNT-1:0] rx_valid_in,
  input wire logic [CHANNEL_COUNT*8-1:0] rx_data_in,
  input wire logic [CHANNEL_COUNT-1:0] rx_last_in,
  input wire logic local_valid_in,
  input wire logic [7:0] local_data_in,
  input wire logic local_last_in,
  output logic [CHANNEL_COUNT-1:0] tx_valid_out,
  output logic [CHANNEL_COUNT*8-1:0] tx_data_out,
  output logic [CHANNEL_COUNT-1:0] tx_last_out,
  output logic integrity_req_out,
  output logic [CHANNEL_COUNT-1:0] channel_integrity_alarm_out,
  output logic irq_out
);

  localparam int TW = crc_mon_pkg::TIMER_WIDTH;
  localparam int SW = 2 * CHANNEL_COUNT;

  // ****************************************************************
  // State
  // ****************************************************************
  typedef struct packed {
    logic relay_en;
    logic rate_128k;
    logic [CHANNEL_COUNT-1:0][CW-1:0] fail_count_threshold;
    logic [CHANNEL_COUNT-1:0][CW-1:0] window_message_total;
    logic [CHANNEL_COUNT-1:0][CW-1:0] fail_count;
    logic [CHANNEL_COUNT-1:0][CW-1:0] total_count;
    logic [CHANNEL_COUNT-1:0] alarm;
    logic [CHANNEL_COUNT-1:0][31:0] crc;
    logic [SW-1:0] status;
    logic [SW-1:0] mask;
    logic irq;
    logic [crc_mon_pkg::DATA_WIDTH-1:0] rdata;
    logic [TW-1:0] timer;
    logic integ;
    logic [CHANNEL_COUNT-1:0] tx_valid;
    logic [CHANNEL_COUNT-1:0] tx_last;
    logic [CHANNEL_COUNT-1:0][7:0] tx_data;
  } state_s;

  state_s s_r;
  state_s s_nxt;

  // ****************************************************************
  // Helpers
  // ****************************************************************
  // Reflected CRC-32, one byte per clock, LSB first.
  function automatic logic [31:0] crc_byte(input logic [31:0] c, input logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int b = 0; b < 8; b++)
    begin
      r = r[0] ? ((r >> 1) ^ crc_mon_pkg::CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  // Returns one-hot channel select from a register address, zero if not a channel slot.
  function automatic logic [CHANNEL_COUNT-1:0] chan_hit(input logic [7:0] a);
    logic [CHANNEL_COUNT-1:0] h;
    h = '0;
    for (int c = 0; c < CHANNEL_COUNT; c++)
    begin
      if (a[7:4] == 4'(c + 1) && a[1:0] == 2'h0)
      begin
        h[c] = 1'b1;
      end
    end
    return h;
  endfunction

  function automatic logic [31:0] widen(input logic [CW-1:0] v);
    return {{(32 - CW){1'b0}}, v};
  endfunction

  localparam logic [TW-1:0] P64 = TW'(PERIOD_64K - 1);
  localparam logic [TW-1:0] P128 = TW'(PERIOD_128K - 1);

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb
  begin
    logic [31:0] crc_n;
    logic [CW-1:0] tot_n;
    logic [CW-1:0] fail_n;
    logic [SW-1:0] events;
    logic [CHANNEL_COUNT-1:0] wr_hit;
    logic [CHANNEL_COUNT-1:0] rd_hit;
    logic [TW-1:0] period;
    int o;
    crc_n = '0;
    tot_n = '0;
    fail_n = '0;
    events = '0;
    wr_hit = chan_hit(reg_addr_in);
    rd_hit = wr_hit;
    period = '0;
    o = 0;
    s_nxt = s_r;
    s_nxt.integ = 1'b0;
    s_nxt.rdata = '0;

    // Receive side: one independent monitor per channel.
    for (int c = 0; c < CHANNEL_COUNT; c++)
    begin
      if (rx_valid_in[c])
      begin
        crc_n = crc_byte(s_r.crc[c], rx_data_in[c*8 +: 8]);
        s_nxt.crc[c] = crc_n;
        if (rx_last_in[c])
        begin
          s_nxt.crc[c] = crc_mon_pkg::CRC_INIT;
          tot_n = s_r.total_count[c] + 1'b1;
          fail_n = s_r.fail_count[c] + CW'(crc_n != crc_mon_pkg::CRC_RESIDUE);
          if (tot_n >= s_r.window_message_total[c])
          begin
            // The message that fills the window only restarts it.
            s_nxt.total_count[c] = '0;
            s_nxt.fail_count[c] = '0;
            s_nxt.alarm[c] = 1'b0;
            events[CHANNEL_COUNT + c] = 1'b1;
          end
          else
          begin
            s_nxt.total_count[c] = tot_n;
            s_nxt.fail_count[c] = fail_n;
            if (s_r.fail_count_threshold[c] != '0 && fail_n >= s_r.fail_count_threshold[c])
            begin
              // Held to window end; no acknowledge path exists here.
              s_nxt.alarm[c] = 1'b1;
              events[c] = !s_r.alarm[c];
            end
          end
        end
      end
    end

    // Transmit side. Local messages go out on every channel at once so
    // that a dual ring carries them both ways round.
    for (int c = 0; c < CHANNEL_COUNT; c++)
    begin
      o = (c + 1) % CHANNEL_COUNT;
      s_nxt.tx_valid[c] = 1'b0;
      s_nxt.tx_last[c] = 1'b0;
      s_nxt.tx_data[c] = '0;
      if (local_valid_in)
      begin
        s_nxt.tx_valid[c] = 1'b1;
        s_nxt.tx_last[c] = local_last_in;
        s_nxt.tx_data[c] = local_data_in;
      end
      else if (s_r.relay_en && rx_valid_in[o])
      begin
        // Cut-through relay: a fixed single register stage per hop.
        s_nxt.tx_valid[c] = 1'b1;
        s_nxt.tx_last[c] = rx_last_in[o];
        s_nxt.tx_data[c] = rx_data_in[o*8 +: 8];
      end
    end

    // Integrity beacon, restarted by any local message end.
    period = s_r.rate_128k ? P128 : P64;
    if (local_valid_in && local_last_in)
    begin
      s_nxt.timer = '0;
    end
    else if (s_r.timer >= period)
    begin
      s_nxt.timer = '0;
      s_nxt.integ = 1'b1;
    end
    else
    begin
      s_nxt.timer = s_r.timer + 1'b1;
    end

    // Register writes.
    if (reg_write_in)
    begin
      case (reg_addr_in)
        crc_mon_pkg::CTRL_ADDR:
        begin
          s_nxt.relay_en = reg_wdata_in[crc_mon_pkg::CTRL_RELAY_BIT];
          s_nxt.rate_128k = reg_wdata_in[crc_mon_pkg::CTRL_RATE_BIT];
        end
        crc_mon_pkg::STATUS_ADDR:
        begin
          s_nxt.status = s_r.status & ~reg_wdata_in[SW-1:0];
        end
        crc_mon_pkg::MASK_ADDR:
        begin
          s_nxt.mask = reg_wdata_in[SW-1:0];
        end
        default:
        begin
          for (int c = 0; c < CHANNEL_COUNT; c++)
          begin
            if (wr_hit[c] && reg_addr_in[3:2] == crc_mon_pkg::FIELD_THRESHOLD)
            begin
              s_nxt.fail_count_threshold[c] = reg_wdata_in[CW-1:0];
            end
            if (wr_hit[c] && reg_addr_in[3:2] == crc_mon_pkg::FIELD_WINDOW)
            begin
              s_nxt.window_message_total[c] = reg_wdata_in[CW-1:0];
            end
          end
        end
      endcase
    end
    // A new event wins over a clear in the same cycle.
    s_nxt.status = s_nxt.status | events;
    s_nxt.irq = |(s_nxt.status & s_nxt.mask);

    // Register reads, answered on the next cycle.
    if (reg_read_in)
    begin
      case (reg_addr_in)
        crc_mon_pkg::CTRL_ADDR:
        begin
          s_nxt.rdata[crc_mon_pkg::CTRL_RELAY_BIT] = s_r.relay_en;
          s_nxt.rdata[crc_mon_pkg::CTRL_RATE_BIT] = s_r.rate_128k;
        end
        crc_mon_pkg::STATUS_ADDR:
        begin
          s_nxt.rdata[SW-1:0] = s_r.status;
        end
        crc_mon_pkg::MASK_ADDR:
        begin
          s_nxt.rdata[SW-1:0] = s_r.mask;
        end
        default:
        begin
          for (int c = 0; c < CHANNEL_COUNT; c++)
          begin
            if (rd_hit[c])
            begin
              case (reg_addr_in[3:2])
                crc_mon_pkg::FIELD_THRESHOLD: s_nxt.rdata = widen(s_r.fail_count_threshold[c]);
                crc_mon_pkg::FIELD_WINDOW: s_nxt.rdata = widen(s_r.window_message_total[c]);
                crc_mon_pkg::FIELD_FAIL: s_nxt.rdata = widen(s_r.fail_count[c]);
                default: s_nxt.rdata = widen(s_r.total_count[c]);
              endcase
            end
          end
        end
      endcase
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge clock_in)
  begin
    if (!reset_n_in)
    begin
      s_r <= '0;
      s_r.fail_count_threshold <= {CHANNEL_COUNT{CW'(crc_mon_pkg::THRESHOLD_RST)}};
      s_r.window_message_total <= {CHANNEL_COUNT{CW'(crc_mon_pkg::WINDOW_RST)}};
      s_r.crc <= {CHANNEL_COUNT{crc_mon_pkg::CRC_INIT}};
    end
    else
    begin
      s_r <= s_nxt;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign reg_rdata_out = s_r.rdata;
  assign tx_valid_out = s_r.tx_valid;
  assign tx_data_out = s_r.tx_data;
  assign tx_last_out = s_r.tx_last;
  assign integrity_req_out = s_r.integ;
  assign channel_integrity_alarm_out = s_r.alarm;
  assign irq_out = s_r.irq;

endmodule

// >>> dv/link_crc_error_rate_monitor_checker.sv
// Port-level assertions for the link integrity monitor.
module link_crc_error_rate_monitor_checker #(
  parameter int CHANNEL_COUNT = 2
) (
  input wire logic clock_in,
  input wire logic reset_n_in,
  input wire logic reg_read_in,
  input wire logic [crc_mon_pkg::DATA_WIDTH-1:0] reg_rdata_out,
  input wire logic [CHANNEL_COUNT-1:0] rx_valid_in,
  input wire logic [CHANNEL_COUNT-1:0] rx_last_in,
  input wire logic local_valid_in,
  input wire logic [7:0] local_data_in,
  input wire logic local_last_in,
  input wire logic [CHANNEL_COUNT-1:0] tx_valid_out,
  input wire logic [CHANNEL_COUNT*8-1:0] tx_data_out,
  input wire logic [CHANNEL_COUNT-1:0] tx_last_out,
  input wire logic integrity_req_out,
  input wire logic [CHANNEL_COUNT-1:0] channel_integrity_alarm_out,
  input wire logic irq_out
);
  timeunit 1ns;
  timeprecision 100ps;
  // **********************************************
  // Properties
  // **********************************************
  default clocking @(posedge clock_in); endclocking
  default disable iff (!reset_n_in);
  // Alarm edges may lag a message end by one or two edges, so both are accepted.
  sequence s_end0;
    $past(rx_valid_in[0] && rx_last_in[0]) || $past(rx_valid_in[0] && rx_last_in[0], 2);
  endsequence
  property p_rd_idle; !$past(reg_read_in) |-> reg_rdata_out == '0; endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside slot");
  property p_tx_valid; local_valid_in |=> tx_valid_out == '1; endproperty
  a_tx_valid: assert property (p_tx_valid) else $error("local byte not on all links");
  property p_tx_data; local_valid_in |=> tx_data_out == {CHANNEL_COUNT{$past(local_data_in)}};
  endproperty
  a_tx_data: assert property (p_tx_data) else $error("local byte value wrong");
  property p_tx_last; local_valid_in |=> tx_last_out == {CHANNEL_COUNT{$past(local_last_in)}};
  endproperty
  a_tx_last: assert property (p_tx_last) else $error("local end marker wrong");
  property p_quiet; !local_valid_in && rx_valid_in == '0 |=> tx_valid_out == '0; endproperty
  a_quiet: assert property (p_quiet) else $error("byte sent from nothing");
  property p_rise0; $rose(channel_integrity_alarm_out[0]) |-> s_end0; endproperty
  a_rise0: assert property (p_rise0) else $error("alarm rose without message");
  property p_rise1; $rose(channel_integrity_alarm_out[1]) |->
    $past(rx_last_in[1]) || $past(rx_last_in[1], 2); endproperty
  a_rise1: assert property (p_rise1) else $error("second alarm without its message");
  property p_fall0; $fell(channel_integrity_alarm_out[0]) |-> s_end0; endproperty
  a_fall0: assert property (p_fall0) else $error("alarm dropped inside window");
  property p_beat; integrity_req_out |=> !integrity_req_out; endproperty
  a_beat: assert property (p_beat) else $error("beacon longer than one cycle");
  property p_restart; local_valid_in && local_last_in |-> ##2 !integrity_req_out [*6];
  endproperty
  a_restart: assert property (p_restart) else $error("beacon soon after local message");
  c_alarm: cover property ($rose(channel_integrity_alarm_out[0]));
  c_beat: cover property (integrity_req_out);
  c_irq: cover property ($rose(irq_out));
endmodule

bind link_crc_error_rate_monitor link_crc_error_rate_monitor_checker
  #(.CHANNEL_COUNT(CHANNEL_COUNT)) chk (
  .clock_in(clock_in),
  .reset_n_in(reset_n_in),
  .reg_read_in(reg_read_in),
  .reg_rdata_out(reg_rdata_out),
  .rx_valid_in(rx_valid_in),
  .rx_last_in(rx_last_in),
  .local_valid_in(local_valid_in),
  .local_data_in(local_data_in),
  .local_last_in(local_last_in),
  .tx_valid_out(tx_valid_out),
  .tx_data_out(tx_data_out),
  .tx_last_out(tx_last_out),
  .integrity_req_out(integrity_req_out),
  .channel_integrity_alarm_out(channel_integrity_alarm_out),
  .irq_out(irq_out)
);

// >>> dv/peer_link_model.sv
// Peer device model: sends status messages with a trailing CRC-32 on one link.
module peer_link_model (
  input wire logic clock_in,
  output logic valid_out,
  output logic [7:0] data_out,
  output logic last_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0] seq_r = 8'h00;
  initial {valid_out, data_out, last_out} = 10'h000;
  function automatic logic [31:0] crc_step(input logic [31:0] c, input logic [7:0] b);
    logic [31:0] r;
    r = c ^ {24'h000000, b};
    repeat (8) r = r[0] ? (r >> 1) ^ crc_mon_pkg::CRC_POLY : r >> 1;
    return r;
  endfunction
  // Idle data shows the inverse of the last byte so stale values never match.
  task automatic send(input logic bad, input logic slow);
    logic [7:0] msg [8];
    logic [31:0] c;
    c = crc_mon_pkg::CRC_INIT;
    for (int i = 0; i < 4; i++)
    begin
      msg[i] = seq_r + 8'(i);
      c = crc_step(c, msg[i]);
    end
    for (int i = 0; i < 4; i++)
      msg[i + 4] = ~c[8 * i +: 8];
    msg[4][0] = msg[4][0] ^ bad;
    seq_r = seq_r + 8'h11;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clock_in);
      valid_out <= 1'b1;
      data_out <= msg[i];
      last_out <= (i == 7);
      if (slow)
      begin
        @(posedge clock_in);
        valid_out <= 1'b0;
        last_out <= 1'b0;
        data_out <= ~msg[i];
      end
    end
    // Slow mode has already released the link after its last byte.
    if (!slow)
    begin
      @(posedge clock_in);
      valid_out <= 1'b0;
      last_out <= 1'b0;
      data_out <= ~msg[7];
    end
  endtask
endmodule

// >>> dv/link_crc_error_rate_monitor_tb.sv
// Self-checking bench for the link integrity monitor.
module link_crc_error_rate_monitor_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clock_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [7:0] reg_addr_in = 8'h00;
  logic [31:0] reg_wdata_in = 32'h0;
  logic reg_write_in = 1'b0;
  logic reg_read_in = 1'b0;
  logic local_valid_in = 1'b0;
  logic [7:0] local_data_in = 8'h00;
  logic local_last_in = 1'b0;
  wire logic [31:0] reg_rdata_out;
  wire logic [1:0] rx_valid, rx_last, tx_valid_out, tx_last_out, alarm;
  wire logic [15:0] rx_data, tx_data_out;
  wire logic integrity_req_out, irq_out;
  int n_errors = 0, checks = 0, cycles = 0, n_tx0 = 0, n_beat = 0, base;
  int n_hop = 0, base_hop;
  logic [8:0] rx1_r = 9'h000;
  always #12.5 clock_in = ~clock_in;
  link_crc_error_rate_monitor #(.PERIOD_64K(20), .PERIOD_128K(10)) uut (.clock_in(clock_in),
    .reset_n_in(reset_n_in), .reg_addr_in(reg_addr_in), .reg_wdata_in(reg_wdata_in),
    .reg_write_in(reg_write_in), .reg_read_in(reg_read_in), .reg_rdata_out(reg_rdata_out),
    .rx_valid_in(rx_valid), .rx_data_in(rx_data), .rx_last_in(rx_last),
    .local_valid_in(local_valid_in), .local_data_in(local_data_in),
    .local_last_in(local_last_in), .tx_valid_out(tx_valid_out), .tx_data_out(tx_data_out),
    .tx_last_out(tx_last_out), .integrity_req_out(integrity_req_out),
    .channel_integrity_alarm_out(alarm), .irq_out(irq_out));
  peer_link_model p0 (.clock_in(clock_in), .valid_out(rx_valid[0]), .data_out(rx_data[7:0]),
    .last_out(rx_last[0]));
  peer_link_model p1 (.clock_in(clock_in), .valid_out(rx_valid[1]), .data_out(rx_data[15:8]),
    .last_out(rx_last[1]));
  // **********************************************
  // Shared tasks
  // **********************************************
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", checks, n_errors);
    if (n_errors == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  always @(posedge clock_in)
  begin
    cycles <= cycles + 1;
    n_tx0 <= n_tx0 + int'(tx_valid_out[0]);
    n_beat <= n_beat + int'(integrity_req_out);
    // A relayed byte must leave on link 0 exactly one cycle after it arrived on link 1.
    rx1_r <= {rx_valid[1], rx_data[15:8]};
    n_hop <= n_hop + int'(tx_valid_out[0] && rx1_r == {1'b1, tx_data_out[7:0]});
    if (cycles == 6000)
    begin
      n_errors++;
      tally_and_finish();
    end
  end
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_wdata_in <= d;
    reg_write_in <= 1'b1;
    @(posedge clock_in);
    reg_write_in <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    @(posedge clock_in);
    reg_addr_in <= a;
    reg_read_in <= 1'b1;
    @(posedge clock_in);
    reg_read_in <= 1'b0;
    #1 cmp(reg_rdata_out, e);
  endtask
  task automatic pause;
    repeat (3) @(posedge clock_in);
    #1;
  endtask
  // **********************************************
  // Scenarios
  // **********************************************
  task automatic t_reset_values;
    rd(8'h10, 32'h0000000A);
    rd(8'h24, 32'h00000258);
    rd(8'h00, 32'h0);
    wr(8'h18, 32'h5);
    wr(8'hFC, 32'h5);
    rd(8'h18, 32'h0);
    rd(8'hFC, 32'h0);
    $display("done reset values");
  endtask
  task automatic t_window;
    wr(8'h10, 32'h3);
    wr(8'h14, 32'h6);
    p0.send(1'b0, 1'b0);
    p0.send(1'b1, 1'b0);
    p0.send(1'b0, 1'b1);
    p0.send(1'b1, 1'b0);
    pause();
    cmp(32'(alarm), 32'h0);
    rd(8'h1C, 32'h4);
    rd(8'h18, 32'h2);
    rd(8'h2C, 32'h0);
    p0.send(1'b1, 1'b0);
    pause();
    cmp(32'(alarm), 32'h1);
    rd(8'h04, 32'h1);
    wr(8'h08, 32'h5);
    pause();
    cmp(32'(irq_out), 32'h1);
    wr(8'h04, 32'h1);
    pause();
    cmp(32'({irq_out, alarm}), 32'h1);
    p0.send(1'b0, 1'b0);
    pause();
    cmp(32'({irq_out, alarm}), 32'h4);
    rd(8'h1C, 32'h0);
    rd(8'h18, 32'h0);
    rd(8'h04, 32'h4);
    wr(8'h04, 32'h4);
    wr(8'h08, 32'h0);
    $display("done window");
  endtask
  task automatic t_relay;
    base = n_tx0;
    p1.send(1'b0, 1'b1);
    pause();
    cmp(n_tx0 - base, 32'd0);
    wr(8'h00, 32'h1);
    wr(8'h20, 32'h1);
    base = n_tx0;
    base_hop = n_hop;
    p1.send(1'b1, 1'b1);
    pause();
    cmp(n_tx0 - base, 32'd8);
    cmp(n_hop - base_hop, 32'd8);
    cmp(32'(alarm), 32'h2);
    rd(8'h2C, 32'h2);
    rd(8'h28, 32'h1);
    wr(8'h00, 32'h0);
    $display("done relay");
  endtask
  task automatic t_local;
    @(posedge clock_in);
    local_valid_in <= 1'b1;
    local_data_in <= 8'hA5;
    local_last_in <= 1'b1;
    @(posedge clock_in);
    local_valid_in <= 1'b0;
    local_last_in <= 1'b0;
    local_data_in <= 8'h5A;
    #1 cmp({tx_valid_out, tx_last_out, tx_data_out}, 32'h000FA5A5);
    $display("done local");
  endtask
  task automatic t_beacon;
    base = n_beat;
    repeat (200) @(posedge clock_in);
    cmp(32'(n_beat - base >= 9 && n_beat - base <= 10), 32'h1);
    wr(8'h00, 32'h2);
    base = n_beat;
    repeat (200) @(posedge clock_in);
    cmp(32'(n_beat - base >= 19 && n_beat - base <= 20), 32'h1);
    $display("done beacon");
  endtask
  initial
  begin
    repeat (5) @(posedge clock_in);
    reset_n_in <= 1'b1;
    t_reset_values();
    t_window();
    t_relay();
    t_local();
    t_beacon();
    tally_and_finish();
  end
endmodule
